// ### rt_flags_pkg.sv
// Constants for the remote terminal status flag register bank
package rt_flags_pkg;
   // Register byte offsets on the register bus
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_LAST_RESP = 8'h10;

   // Flag register field positions
   localparam int TF_POS = 0;
   localparam int BCA_POS = 1;
   localparam int SSF_POS = 2;
   localparam int BUSY_POS = 3;
   localparam int BCAST_POS = 4;
   localparam int SVC_POS = 8;
   localparam int INST_POS = 9;
   localparam int MERR_POS = 10;
   localparam int TXCLR_POS = 15;
   // Host-writable bits (15, 9-8, 3-0) and the bits a transmit-then-clear wipes (15, 9-5, 3-0)
   localparam logic [15:0] FLAGS_WR_MASK = 16'h830f;
   localparam logic [15:0] TXCLR_WIPE_MASK = 16'h83ef;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;

   // Configuration register fields
   localparam int VEC_OPT_POS = 0;
   localparam int BUSY_INT_OPT_POS = 2;
   localparam logic [2:0] CONFIG_RESET = 3'h0;

   // Interrupt status / mask fields
   localparam int IRQ_MSG_DONE_POS = 0;
   localparam int IRQ_SSF_CLEARED_POS = 1;
   localparam int IRQ_W = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // Mode codes of interest
   localparam logic [4:0] MC_TX_VECTOR = 5'h10;
   localparam int STATUS_BITS_W = 11;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_state_t;
endpackage

// ### rt_status_word_flag_bits.sv
// Status flag register bank of a 1553 remote terminal with an Avalon-MM slave
// Summary of operation
// - Busy flag sets Busy in every response
// - Descriptor busy bit sets Busy per command
// - Busy response suppresses transmit data words
// - Busy message sets was-busy in message info
// - Busy interrupt option adds was-busy bit
// - Busy alone raises no interrupt
// - Subsystem flag is register OR pin
// - Vector word command clears subsystem fail bit
// - Terminal flag bit sets status terminal flag
// - Terminal flag suppresses transmitted data words
// - Register bits 10-0 go into status word
// - Transmit-then-clear wipes bits after status sent
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module rt_status_word_flag_bits
   import rt_flags_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // External subsystem fail pin, asynchronous
   input wire logic subsystem_fail_input_pin,
   // Protocol engine: valid command decoded, response about to start
   input wire logic cmd_valid,
   input wire logic cmd_transmit,
   input wire logic cmd_mode,
   input wire logic [4:0] cmd_mode_code,
   input wire logic cmd_desc_busy,
   // Protocol engine: status word has left the transmitter
   input wire logic status_sent,
   // Protocol engine: message finished, with its outcome
   input wire logic msg_done,
   input wire logic msg_error,
   input wire logic msg_broadcast,
   // Response control toward the encoder
   output logic resp_valid,
   output logic [STATUS_BITS_W-1:0] status_word_bits,
   output logic resp_busy,
   output logic suppress_data,
   output logic bus_control_accept_flag,
   // Message and interrupt information words toward the buffer writer
   output logic info_valid,
   output logic was_busy_flag,
   output logic was_busy_interrupt_bit,
   output logic irq
);

   // Synchroniser for the pin; only stage two is read by logic
   logic ssf_pin_meta_q;
   logic ssf_pin_q;

   logic [15:0] flags_q;
   logic [15:0] flags_d;
   logic [2:0] config_q;
   logic [2:0] config_d;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_status_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_mask_d;
   bus_state_t bus_state_q;
   bus_state_t bus_state_d;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;

   logic resp_valid_q;
   logic [STATUS_BITS_W-1:0] status_bits_q;
   logic resp_busy_q;
   logic suppress_q;
   logic msg_busy_q;
   logic txclr_armed_q;
   logic txclr_armed_d;
   logic info_valid_q;
   logic was_busy_q;
   logic was_busy_int_q;

   // Register bus decode
   wire bus_req = avs_read | avs_write;
   wire bus_take = bus_req && (bus_state_q == BUS_ACK);
   wire wr_take = bus_take && avs_write;
   // Read data is loaded in the wait cycle so it already stands at the accepting
   // edge; a register change landing on that same edge shows on the next read
   wire rd_load = avs_read && (bus_state_q == BUS_IDLE);
   wire sel_flags = (avs_address == OFS_FLAGS);
   wire sel_config = (avs_address == OFS_CONFIG);
   wire sel_irq_status = (avs_address == OFS_IRQ_STATUS);
   wire sel_irq_mask = (avs_address == OFS_IRQ_MASK);
   wire sel_last = (avs_address == OFS_LAST_RESP);

   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be);
      logic [15:0] r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         r[15:8] = wdata[15:8];
      end
      return r;
   endfunction

   wire [15:0] flags_wr_val = lane_merge(flags_q, avs_writedata, avs_byteenable);
   wire [15:0] config_wr_val = lane_merge({13'h0000, config_q}, avs_writedata,
                                          avs_byteenable);
   wire [15:0] w1c_val = lane_merge(16'h0000, avs_writedata, avs_byteenable);
   wire [15:0] mask_wr_val = lane_merge({14'h0000, irq_mask_q}, avs_writedata,
                                        avs_byteenable);
   wire flags_wr = wr_take && sel_flags;

   // Command classification
   wire vec_opt = config_q[VEC_OPT_POS];
   wire busy_int_opt = config_q[BUSY_INT_OPT_POS];
   wire is_tx_vector = cmd_mode && cmd_transmit && (cmd_mode_code == MC_TX_VECTOR);
   wire ssf_auto_clear = cmd_valid && is_tx_vector && !vec_opt;
   // Subaddress transmit, or a mode code 16-31 that sends a data word
   wire data_bearing_tx = cmd_transmit && (!cmd_mode || cmd_mode_code[4]);
   wire busy_now = flags_q[BUSY_POS] | cmd_desc_busy;
   wire tf_now = flags_q[TF_POS];
   wire ssf_reg_now = flags_q[SSF_POS] && !ssf_auto_clear;
   // The snapshot is taken at command time so host writes hit the next response
   wire [STATUS_BITS_W-1:0] status_now = {flags_q[MERR_POS:BUSY_POS+1],
                                          busy_now,
                                          ssf_reg_now | ssf_pin_q,
                                          flags_q[BCA_POS],
                                          tf_now};
   wire suppress_now = data_bearing_tx && (busy_now || tf_now);
   wire txclr_fire = status_sent && txclr_armed_q;

   // Flag register next value
   always_comb begin
      flags_d = flags_q;
      if (txclr_fire) begin
         flags_d = flags_q & ~TXCLR_WIPE_MASK;
      end
      if (ssf_auto_clear) begin
         flags_d[SSF_POS] = 1'b0;
      end
      if (msg_done) begin
         flags_d[MERR_POS] = msg_error;
         flags_d[BCAST_POS] = msg_broadcast;
      end
      // A host write beats the automatic clears so a fresh set is not lost
      if (flags_wr) begin
         flags_d = (flags_d & ~FLAGS_WR_MASK) | (flags_wr_val & FLAGS_WR_MASK);
      end
   end

   // Transmit-then-clear is armed for the response whose command saw it set
   always_comb begin
      txclr_armed_d = txclr_armed_q;
      if (cmd_valid) begin
         txclr_armed_d = flags_q[TXCLR_POS];
      end else if (status_sent) begin
         txclr_armed_d = 1'b0;
      end
   end

   always_comb begin
      config_d = config_q;
      if (wr_take && sel_config) begin
         config_d = config_wr_val[2:0];
      end
   end

   // Busy never raises an event by itself; only message completion and the
   // automatic subsystem fail clear do
   wire [IRQ_W-1:0] irq_events = {ssf_auto_clear, msg_done};
   always_comb begin
      irq_status_d = irq_status_q;
      if (wr_take && sel_irq_status) begin
         irq_status_d = irq_status_q & ~w1c_val[IRQ_W-1:0];
      end
      irq_status_d = irq_status_d | irq_events;
   end

   always_comb begin
      irq_mask_d = irq_mask_q;
      if (wr_take && sel_irq_mask) begin
         irq_mask_d = mask_wr_val[IRQ_W-1:0];
      end
   end

   // Read mux; unmapped addresses read zero and ignore writes
   always_comb begin
      readdata_d = 32'h0000_0000;
      if (sel_flags) begin
         readdata_d[15:0] = flags_q;
      end else if (sel_config) begin
         readdata_d[2:0] = config_q;
      end else if (sel_irq_status) begin
         readdata_d[IRQ_W-1:0] = irq_status_q;
      end else if (sel_irq_mask) begin
         readdata_d[IRQ_W-1:0] = irq_mask_q;
      end else if (sel_last) begin
         readdata_d[STATUS_BITS_W-1:0] = status_bits_q;
         readdata_d[16] = resp_busy_q;
         readdata_d[17] = suppress_q;
         readdata_d[18] = ssf_pin_q;
      end
   end

   // One wait cycle per access, then the answer
   always_comb begin
      bus_state_d = BUS_IDLE;
      case (bus_state_q)
         BUS_IDLE: begin
            bus_state_d = bus_req ? BUS_ACK : BUS_IDLE;
         end
         BUS_ACK: begin
            bus_state_d = BUS_IDLE;
         end
         default: begin
            bus_state_d = BUS_IDLE;
         end
      endcase
   end

   assign avs_waitrequest = bus_req && (bus_state_q != BUS_ACK);
   assign avs_readdata = readdata_q;

   always_ff @(posedge sys_clk) begin
      ssf_pin_meta_q <= subsystem_fail_input_pin;
      ssf_pin_q <= ssf_pin_meta_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flags_q <= FLAGS_RESET;
         config_q <= CONFIG_RESET;
         irq_status_q <= IRQ_RESET;
         irq_mask_q <= IRQ_RESET;
         bus_state_q <= BUS_IDLE;
         txclr_armed_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         config_q <= config_d;
         irq_status_q <= irq_status_d;
         irq_mask_q <= irq_mask_d;
         bus_state_q <= bus_state_d;
         txclr_armed_q <= txclr_armed_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         readdata_q <= 32'h0000_0000;
      end else if (rd_load) begin
         readdata_q <= readdata_d;
      end
   end

   // Response snapshot, held until the next command
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         resp_valid_q <= 1'b0;
         status_bits_q <= '0;
         resp_busy_q <= 1'b0;
         suppress_q <= 1'b0;
         msg_busy_q <= 1'b0;
      end else begin
         resp_valid_q <= cmd_valid;
         if (cmd_valid) begin
            status_bits_q <= status_now;
            resp_busy_q <= busy_now;
            suppress_q <= suppress_now;
            msg_busy_q <= busy_now;
         end
      end
   end

   // Message and interrupt information word flags, one pulse per message
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         info_valid_q <= 1'b0;
         was_busy_q <= 1'b0;
         was_busy_int_q <= 1'b0;
      end else begin
         info_valid_q <= msg_done;
         if (msg_done) begin
            was_busy_q <= msg_busy_q;
            was_busy_int_q <= msg_busy_q && busy_int_opt;
         end
      end
   end

   assign resp_valid = resp_valid_q;
   assign status_word_bits = status_bits_q;
   assign resp_busy = resp_busy_q;
   assign suppress_data = suppress_q;
   // The bus controller's dynamic bus control command is accepted only if set
   assign bus_control_accept_flag = flags_q[BCA_POS];
   assign info_valid = info_valid_q;
   assign was_busy_flag = was_busy_q;
   assign was_busy_interrupt_bit = was_busy_int_q;
   assign irq = |(irq_status_q & irq_mask_q);

endmodule

// ### rt_flags_properties.sv
// Port-level property checks for the status flag register bank
`timescale 1ns/100ps
module rt_flags_properties
   import rt_flags_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic avs_write,
   input wire logic subsystem_fail_input_pin,
   input wire logic cmd_valid,
   input wire logic cmd_transmit,
   input wire logic cmd_mode,
   input wire logic cmd_desc_busy,
   input wire logic msg_done,
   input wire logic resp_valid,
   input wire logic [STATUS_BITS_W-1:0] status_word_bits,
   input wire logic resp_busy,
   input wire logic suppress_data,
   input wire logic info_valid,
   input wire logic was_busy_flag,
   input wire logic was_busy_interrupt_bit,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   a_desc_busy: assert property (cmd_valid && cmd_desc_busy |=> resp_valid && resp_busy)
      else $error("descriptor busy not reported");
   a_busy_drop: assert property (resp_valid && resp_busy && $past(cmd_transmit && !cmd_mode)
      |-> suppress_data)
      else $error("busy transmit reply kept its data");
   a_tf_drop: assert property (resp_valid && status_word_bits[0] &&
      $past(cmd_transmit && !cmd_mode) |-> suppress_data)
      else $error("terminal flag reply kept its data");
   a_rx_keep: assert property (cmd_valid && !cmd_transmit |=> !suppress_data)
      else $error("receive reply suppressed");
   // Four samples cover the two-stage pin synchroniser
   a_pin_or: assert property (subsystem_fail_input_pin [*4] ##0 cmd_valid
      |=> status_word_bits[2])
      else $error("subsystem pin not in status");
   a_info_pulse: assert property (msg_done |=> info_valid ##1 !info_valid)
      else $error("message info not a single pulse");
   a_wbi_needs: assert property (info_valid && was_busy_interrupt_bit |-> was_busy_flag)
      else $error("was-busy interrupt bit without busy");
   a_irq_cause: assert property ($rose(irq) |-> $past(msg_done || cmd_valid || avs_write))
      else $error("interrupt rose without an event");
   a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !resp_valid && !irq &&
      !info_valid && status_word_bits == '0)
      else $error("outputs not clear after reset");
endmodule
bind rt_status_word_flag_bits rt_flags_properties chk_u (.*);

// ### bc_model.sv
// Bus controller model: issues one command and walks its message
`timescale 1ns/100ps
module bc_model
   import rt_flags_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resp_valid,
   input wire logic [STATUS_BITS_W-1:0] status_word_bits,
   input wire logic resp_busy,
   input wire logic suppress_data,
   input wire logic info_valid,
   input wire logic was_busy_flag,
   input wire logic was_busy_interrupt_bit,
   output logic cmd_valid,
   output logic cmd_transmit,
   output logic cmd_mode,
   output logic [4:0] cmd_mode_code,
   output logic cmd_desc_busy,
   output logic status_sent,
   output logic msg_done
);
   logic [STATUS_BITS_W-1:0] r_bits;
   logic r_busy, r_sup, r_wb, r_wbi;
   int gap = 0;
   initial begin
      cmd_valid = 1'b0;
      cmd_transmit = 1'b0;
      cmd_mode = 1'b0;
      cmd_mode_code = 5'h00;
      cmd_desc_busy = 1'b0;
      status_sent = 1'b0;
      msg_done = 1'b0;
   end
   task automatic send(input logic t, input logic m, input logic [4:0] c, input logic db);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_transmit <= t;
      cmd_mode <= m;
      cmd_mode_code <= c;
      cmd_desc_busy <= db;
      @(posedge sys_clk);
      // Stale command fields are inverted so nothing can lean on them
      cmd_valid <= 1'b0;
      cmd_transmit <= ~t;
      cmd_mode <= ~m;
      cmd_mode_code <= ~c;
      cmd_desc_busy <= ~db;
      @(posedge sys_clk);
      r_bits = status_word_bits;
      r_busy = resp_valid & resp_busy;
      r_sup = suppress_data;
      repeat (gap) @(posedge sys_clk);
      status_sent <= 1'b1;
      @(posedge sys_clk);
      status_sent <= 1'b0;
      msg_done <= 1'b1;
      @(posedge sys_clk);
      msg_done <= 1'b0;
      @(posedge sys_clk);
      r_wb = info_valid & was_busy_flag;
      r_wbi = info_valid & was_busy_interrupt_bit;
   endtask
endmodule

// ### rt_status_word_flag_bits_tb.sv
// Self-checking bench for the status flag register bank
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module rt_status_word_flag_bits_tb;
   import rt_flags_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h3;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic subsystem_fail_input_pin = 1'b0;
   logic msg_error = 1'b0;
   logic msg_broadcast = 1'b0;
   logic cmd_valid, cmd_transmit, cmd_mode, cmd_desc_busy, status_sent, msg_done;
   logic [4:0] cmd_mode_code;
   logic resp_valid, resp_busy, suppress_data, bus_control_accept_flag, info_valid;
   logic was_busy_flag, was_busy_interrupt_bit, irq;
   logic [STATUS_BITS_W-1:0] status_word_bits;
   logic [4:0] codes[3] = '{5'h0f, 5'h10, 5'h1f};
   int n_mismatch = 0;
   int checked = 0;
   rt_status_word_flag_bits dut_u (.*);
   bc_model bc_u (.*);
   initial forever #2 sys_clk = ~sys_clk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      q = 32'h0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {16'h0, d};
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         $display("[FAIL] %0t bus timeout", $time);
         close_out();
      end
      // Read data stands at the accepting edge
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // One idle edge lets register updates from the accepting edge settle
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0, q);
      `CHK(q[15:0], e)
   endtask
   task automatic msg(input logic t, input logic m, input logic [4:0] c, input logic db,
                      input logic eb, input logic es);
      bc_u.send(t, m, c, db);
      `CHK(bc_u.r_busy, eb)
      `CHK(bc_u.r_sup, es)
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(OFS_FLAGS, 16'h0000);
      rd(OFS_CONFIG, 16'h0000);
      rd(8'h40, 16'h0000);
      wr(OFS_FLAGS, 16'h0008);
      msg(1'b0, 1'b0, 5'h01, 1'b0, 1'b1, 1'b0);
      msg(1'b1, 1'b0, 5'h01, 1'b0, 1'b1, 1'b1);
      `CHK(bc_u.r_wb, 1'b1)
      `CHK(bc_u.r_wbi, 1'b0)
      wr(OFS_FLAGS, 16'h0000);
      wr(OFS_CONFIG, 16'h0004);
      bc_u.gap = 3;
      msg(1'b1, 1'b0, 5'h03, 1'b1, 1'b1, 1'b1);
      `CHK(bc_u.r_wbi, 1'b1)
      msg(1'b0, 1'b0, 5'h03, 1'b0, 1'b0, 1'b0);
      `CHK(bc_u.r_wb, 1'b0)
      wr(OFS_FLAGS, 16'h0001);
      foreach (codes[i]) begin
         msg(1'b1, 1'b1, codes[i], 1'b0, 1'b0, codes[i][4]);
      end
      `CHK(bc_u.r_bits[TF_POS], 1'b1)
      msg(1'b0, 1'b0, 5'h04, 1'b0, 1'b0, 1'b0);
      wr(OFS_CONFIG, 16'h0000);
      wr(OFS_FLAGS, 16'h0004);
      msg(1'b1, 1'b1, MC_TX_VECTOR, 1'b0, 1'b0, 1'b0);
      `CHK(bc_u.r_bits[SSF_POS], 1'b0)
      rd(OFS_FLAGS, 16'h0000);
      wr(OFS_CONFIG, 16'h0001);
      wr(OFS_FLAGS, 16'h0004);
      msg(1'b1, 1'b1, MC_TX_VECTOR, 1'b0, 1'b0, 1'b0);
      rd(OFS_FLAGS, 16'h0004);
      wr(OFS_FLAGS, 16'h0000);
      subsystem_fail_input_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      msg(1'b0, 1'b0, 5'h01, 1'b0, 1'b0, 1'b0);
      `CHK(bc_u.r_bits[SSF_POS], 1'b1)
      subsystem_fail_input_pin <= 1'b0;
      rd(OFS_IRQ_STATUS, 16'h0003);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MASK, 16'h0002);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_STATUS, 16'h0002);
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_STATUS, 16'h0001);
      wr(OFS_FLAGS, 16'h830f);
      `CHK(bus_control_accept_flag, 1'b1)
      msg(1'b0, 1'b0, 5'h01, 1'b0, 1'b1, 1'b0);
      `CHK(bc_u.r_bits, 11'h30f)
      rd(OFS_LAST_RESP, 16'h030f);
      rd(OFS_FLAGS, 16'h0000);
      `CHK(bus_control_accept_flag, 1'b0)
      msg_error <= 1'b1;
      msg_broadcast <= 1'b1;
      msg(1'b0, 1'b0, 5'h01, 1'b0, 1'b0, 1'b0);
      msg_error <= 1'b0;
      msg_broadcast <= 1'b0;
      rd(OFS_FLAGS, 16'h0410);
      msg(1'b0, 1'b0, 5'h01, 1'b0, 1'b0, 1'b0);
      `CHK(bc_u.r_bits, 11'h410)
      close_out();
   end
endmodule
